// File: hdl/tone_generator.sv
// Key-click tone generator and mixer in front of the mono DAC input.
// Operation
// R1 - Synthesise sine burst into DAC path.
// R2 - Sine coefficient bytes at 76, 77.
// R3 - Cosine coefficient bytes at 78, 79.
// R4 - 24-bit burst length in registers 73-75.
// R5 - One length unit per sample period.
// R6 - Length, sine, cosine bytes reset to defaults.
// R7 - Left tone level in register 71 bits.
// R8 - Right tone level in register 72.
// R9 - Master volume bits govern both channels.
// R10 - Volume fields reset to +2 dB.
// R11 - Tone added after playback volume stage.
// R12 - Host zero-fills unused coefficient upper bits.
// R13 - Host zero-fills unused length upper bits.
// R14 - Host keeps tone below quarter sample rate.
// R15 - Host computes length from rate, cycles.
// R16 - Host loads settings before the tone.
// R17 - Playback muted while the tone sounds.
// R18 - System avoids DAC clocks for serial clocks.
// R19 - Host loads filters before DAC power-up.
// R20 - Boot coefficient load takes 100 us.
// R21 - Host avoids coefficient pages during boot.
// R22 - Mono selector: left, right or average.
// R23 - Oscillator rotates by sine, cosine coefficients.
// R24 - Count down length, then output zero.
`default_nettype none
module tone_generator #(
	parameter int unsigned BOOT_LOAD_CYCLES = tone_pkg::BOOT_LOAD_CYC
) (
	input  wire logic        clk_sys_i,
	input  wire logic        nrst_i,
	input  wire logic        ce_i,
	input  wire logic        reg_wr_i,
	input  wire logic        reg_rd_i,
	input  wire logic [7:0]  reg_addr_i,
	input  wire logic [7:0]  reg_wdata_i,
	output logic      [7:0]  reg_rdata_o,
	input  wire logic        pb_valid_i,
	output logic             pb_ready_o,
	input  wire logic [15:0] pb_left_i,
	input  wire logic [15:0] pb_right_i,
	output logic             dac_valid_o,
	input  wire logic        dac_ready_i,
	output logic      [15:0] dac_data_o,
	output logic             tone_active_o,
	output logic             coef_load_busy_o
);
	tone_pkg::tone_state_t state_r;
	logic [7:0]  mono_r;
	logic [7:0]  left_r;
	logic [7:0]  right_r;
	logic [7:0]  len_h_r;
	logic [7:0]  len_m_r;
	logic [7:0]  len_l_r;
	logic [7:0]  sin_h_r;
	logic [7:0]  sin_l_r;
	logic [7:0]  cos_h_r;
	logic [7:0]  cos_l_r;
	logic        mute_r;
	logic [7:0]  reg_rdata_r;
	logic [tone_pkg::BOOT_CNT_W-1:0] boot_cnt_r;
	logic [tone_pkg::LEN_W-1:0]      count_r;
	logic [tone_pkg::LEN_W-1:0]      length;
	logic signed [15:0] y_r;
	logic signed [15:0] x_r;
	logic signed [15:0] y_nxt;
	logic signed [15:0] x_nxt;
	logic signed [15:0] sin_c;
	logic signed [15:0] cos_c;
	logic signed [15:0] tone_smp;
	logic signed [16:0] tone_l;
	logic signed [16:0] tone_r;
	logic signed [15:0] pb_l;
	logic signed [15:0] pb_r;
	logic signed [15:0] mix_l;
	logic signed [15:0] mix_r;
	logic signed [15:0] avg;
	logic [15:0] mono_smp;
	logic        dac_valid_r;
	logic [15:0] dac_data_r;
	logic        pb_gate;
	logic        start_wr;
	logic        pop;
	logic        sel;

	sample_stream_if #(.W(tone_pkg::FIFO_W)) pb_s ();

	// Incoming playback words wait here; a stalled DAC backs up to pb_ready_o.
	tone_fifo #(
		.WIDTH(tone_pkg::FIFO_W),
		.DEPTH(tone_pkg::FIFO_DEPTH)
	) u_fifo (
		.clk_sys_i(clk_sys_i),
		.nrst_i   (nrst_i),
		.ce_i     (ce_i),
		.s        (pb_s.fifo)
	);

	assign pb_s.in_valid  = pb_valid_i;
	assign pb_s.in_data   = {pb_left_i, pb_right_i};
	assign pb_s.out_ready = pop;

	// One popped playback word is one sample period for the tone as well.
	assign pop      = ce_i & pb_s.out_valid & (~dac_valid_r | dac_ready_i); // R5
	assign sel      = reg_wr_i & ce_i;
	assign start_wr = sel & (reg_addr_i == tone_pkg::ADDR_CONTROL)
		& reg_wdata_i[tone_pkg::CTRL_START];
	assign length   = {len_h_r, len_m_r, len_l_r}; // R4
	assign sin_c    = {sin_h_r, sin_l_r}; // R2
	assign cos_c    = {cos_h_r, cos_l_r}; // R3

	// Scales a tone sample by a level plus master attenuation in 1 dB steps.
	function automatic logic signed [16:0] scale_tone(input logic signed [15:0] smp,
		input logic [5:0] lvl, input logic [1:0] mst);
		logic [6:0] att;
		logic [6:0] shamt;
		logic [2:0] idx;
		logic signed [32:0] prod;
		att   = 7'(lvl) + 7'(mst) * tone_pkg::MASTER_STEP_DB;
		shamt = att / tone_pkg::DB_PER_SHIFT;
		idx   = 3'(att % tone_pkg::DB_PER_SHIFT);
		prod  = 33'(smp) * $signed(33'(tone_pkg::GAIN_MANT[idx]));
		return 17'(prod >>> (tone_pkg::GAIN_FRAC + shamt));
	endfunction

	// Clips an extended sum back to the DAC word width.
	function automatic logic signed [15:0] sat16(input logic signed [17:0] s);
		logic signed [15:0] r;
		r = 16'(s);
		if (s > 18'(tone_pkg::SAMPLE_MAX)) begin
			r = tone_pkg::SAMPLE_MAX;
		end else if (s < 18'(tone_pkg::SAMPLE_MIN)) begin
			r = tone_pkg::SAMPLE_MIN;
		end
		return r;
	endfunction

	// Recursive rotation: the sine state advances by the coefficient angle.
	always_comb begin
		logic signed [32:0] acc_y;
		logic signed [32:0] acc_x;
		acc_y = 33'(cos_c) * 33'(y_r) + 33'(sin_c) * 33'(x_r); // R23
		acc_x = 33'(cos_c) * 33'(x_r) - 33'(sin_c) * 33'(y_r); // R23
		y_nxt = 16'(acc_y >>> tone_pkg::COEF_FRAC);
		x_nxt = 16'(acc_x >>> tone_pkg::COEF_FRAC);
	end

	// Playback arrives already volume-set; the tone is added behind it.
	always_comb begin
		tone_smp = (state_r == tone_pkg::ST_RUN) ? y_r : '0; // R24
		pb_gate  = mute_r | (state_r == tone_pkg::ST_RUN); // R17
		tone_l = scale_tone(tone_smp, left_r[tone_pkg::LEVEL_MSB:tone_pkg::LEVEL_LSB],
			right_r[tone_pkg::MASTER_MSB:tone_pkg::MASTER_LSB]); // R7
		tone_r = scale_tone(tone_smp, right_r[tone_pkg::LEVEL_MSB:tone_pkg::LEVEL_LSB],
			right_r[tone_pkg::MASTER_MSB:tone_pkg::MASTER_LSB]); // R8
		pb_l  = pb_gate ? '0 : $signed(pb_s.out_data[31:16]);
		pb_r  = pb_gate ? '0 : $signed(pb_s.out_data[15:0]);
		mix_l = sat16(18'(pb_l) + 18'(tone_l)); // R11
		mix_r = sat16(18'(pb_r) + 18'(tone_r)); // R11
		avg   = 16'((17'(mix_l) + 17'(mix_r)) >>> 1);
		case (tone_pkg::mono_sel_t'(mono_r[tone_pkg::MONO_MSB:tone_pkg::MONO_LSB]))
			tone_pkg::MONO_LEFT: begin
				mono_smp = mix_l; // R22
			end
			tone_pkg::MONO_RIGHT: begin
				mono_smp = mix_r; // R22
			end
			tone_pkg::MONO_AVG: begin
				mono_smp = avg; // R22
			end
			default: begin
				mono_smp = '0;
			end
		endcase
	end

	// Configuration registers; the volume fields reset to the loudest setting.
	always_ff @(posedge clk_sys_i) begin
		if (!nrst_i) begin
			mono_r  <= tone_pkg::RST_MONO_SEL;
			left_r  <= tone_pkg::RST_LEFT_LVL; // R10
			right_r <= tone_pkg::RST_RIGHT_LVL; // R10
			len_h_r <= tone_pkg::RST_LEN_HIGH; // R6
			len_m_r <= tone_pkg::RST_LEN_MID; // R6
			len_l_r <= tone_pkg::RST_LEN_LOW; // R6
			sin_h_r <= tone_pkg::RST_SIN_HIGH; // R6
			sin_l_r <= tone_pkg::RST_SIN_LOW; // R6
			cos_h_r <= tone_pkg::RST_COS_HIGH; // R6
			cos_l_r <= tone_pkg::RST_COS_LOW; // R6
			mute_r  <= 1'b0;
		end else if (sel) begin
			case (reg_addr_i)
				tone_pkg::ADDR_MONO_SEL:  mono_r  <= reg_wdata_i;
				tone_pkg::ADDR_LEFT_LVL:  left_r  <= reg_wdata_i; // R7
				tone_pkg::ADDR_RIGHT_LVL: right_r <= reg_wdata_i; // R9
				tone_pkg::ADDR_LEN_HIGH:  len_h_r <= reg_wdata_i;
				tone_pkg::ADDR_LEN_MID:   len_m_r <= reg_wdata_i;
				tone_pkg::ADDR_LEN_LOW:   len_l_r <= reg_wdata_i;
				tone_pkg::ADDR_SIN_HIGH:  sin_h_r <= reg_wdata_i;
				tone_pkg::ADDR_SIN_LOW:   sin_l_r <= reg_wdata_i;
				tone_pkg::ADDR_COS_HIGH:  cos_h_r <= reg_wdata_i;
				tone_pkg::ADDR_COS_LOW:   cos_l_r <= reg_wdata_i;
				tone_pkg::ADDR_CONTROL:   mute_r  <= reg_wdata_i[tone_pkg::CTRL_MUTE];
				default: begin
				end
			endcase
		end
	end

	// Read port answers one cycle after the strobe; unmapped bytes read zero.
	always_ff @(posedge clk_sys_i) begin
		if (!nrst_i) begin
			reg_rdata_r <= '0;
		end else if (ce_i && reg_rd_i) begin
			case (reg_addr_i)
				tone_pkg::ADDR_MONO_SEL:  reg_rdata_r <= mono_r;
				tone_pkg::ADDR_LEFT_LVL:  reg_rdata_r <= left_r;
				tone_pkg::ADDR_RIGHT_LVL: reg_rdata_r <= right_r;
				tone_pkg::ADDR_LEN_HIGH:  reg_rdata_r <= len_h_r;
				tone_pkg::ADDR_LEN_MID:   reg_rdata_r <= len_m_r;
				tone_pkg::ADDR_LEN_LOW:   reg_rdata_r <= len_l_r;
				tone_pkg::ADDR_SIN_HIGH:  reg_rdata_r <= sin_h_r;
				tone_pkg::ADDR_SIN_LOW:   reg_rdata_r <= sin_l_r;
				tone_pkg::ADDR_COS_HIGH:  reg_rdata_r <= cos_h_r;
				tone_pkg::ADDR_COS_LOW:   reg_rdata_r <= cos_l_r;
				tone_pkg::ADDR_CONTROL: begin
					reg_rdata_r <= {5'h00, state_r[tone_pkg::BOOT_IDX], mute_r,
						state_r[tone_pkg::RUN_IDX]};
				end
				default: reg_rdata_r <= '0;
			endcase
		end
	end

	// Boot timer: the coefficient memory is being filled until it expires.
	always_ff @(posedge clk_sys_i) begin
		if (!nrst_i) begin
			boot_cnt_r <= '0;
		end else if (ce_i && state_r == tone_pkg::ST_BOOT) begin
			boot_cnt_r <= boot_cnt_r + 1'b1; // R20
		end
	end

	// Burst sequencer. A start write wins over expiry in the same cycle, and
	// start writes during the boot load are ignored.
	always_ff @(posedge clk_sys_i) begin
		if (!nrst_i) begin
			state_r <= tone_pkg::ST_BOOT;
			count_r <= '0;
			y_r     <= '0;
			x_r     <= tone_pkg::OSC_START;
		end else if (ce_i) begin
			case (state_r)
				tone_pkg::ST_BOOT: begin
					if (boot_cnt_r == tone_pkg::BOOT_CNT_W'(BOOT_LOAD_CYCLES - 1)) begin
						state_r <= tone_pkg::ST_IDLE; // R20
					end
				end
				tone_pkg::ST_IDLE, tone_pkg::ST_RUN: begin
					if (start_wr) begin
						count_r <= length; // R4
						y_r     <= '0;
						x_r     <= tone_pkg::OSC_START;
						state_r <= (length != '0) ? tone_pkg::ST_RUN : tone_pkg::ST_IDLE;
					end else if (pop && state_r == tone_pkg::ST_RUN) begin
						count_r <= count_r - 1'b1; // R24
						y_r     <= y_nxt; // R23
						x_r     <= x_nxt; // R23
						if (count_r == tone_pkg::LEN_W'(1)) begin
							state_r <= tone_pkg::ST_IDLE; // R24
						end
					end
				end
				default: begin
					state_r <= tone_pkg::ST_IDLE;
				end
			endcase
		end
	end

	// Output stage holds a word until the DAC takes it.
	always_ff @(posedge clk_sys_i) begin
		if (!nrst_i) begin
			dac_valid_r <= 1'b0;
			dac_data_r  <= '0;
		end else if (pop) begin
			dac_valid_r <= 1'b1; // R1
			dac_data_r  <= mono_smp; // R1
		end else if (ce_i && dac_ready_i) begin
			dac_valid_r <= 1'b0;
		end
	end

	assign reg_rdata_o      = reg_rdata_r;
	assign pb_ready_o       = pb_s.in_ready;
	assign dac_valid_o      = dac_valid_r;
	assign dac_data_o       = dac_data_r;
	assign tone_active_o    = state_r[tone_pkg::RUN_IDX];
	assign coef_load_busy_o = state_r[tone_pkg::BOOT_IDX];

	default clocking cb @(posedge clk_sys_i);
	endclocking

	sequence s_start;
		ce_i && start_wr && state_r != tone_pkg::ST_BOOT && length != '0;
	endsequence

	sequence s_boot_end;
		ce_i && state_r == tone_pkg::ST_BOOT
			&& boot_cnt_r == tone_pkg::BOOT_CNT_W'(BOOT_LOAD_CYCLES - 1);
	endsequence

	sequence s_last_sample;
		pop && !start_wr && state_r == tone_pkg::ST_RUN && count_r == tone_pkg::LEN_W'(1);
	endsequence

	reset_defaults_a: assert property (!nrst_i |=> len_l_r == tone_pkg::RST_LEN_LOW // R6
		&& sin_l_r == tone_pkg::RST_SIN_LOW && cos_h_r == tone_pkg::RST_COS_HIGH
		&& left_r == tone_pkg::RST_LEFT_LVL && state_r == tone_pkg::ST_BOOT)
		else $error("Registers not at reset values.");

	start_load_a: assert property (disable iff (!nrst_i) s_start |=> // R4
		state_r == tone_pkg::ST_RUN && count_r == $past(length))
		else $error("Burst start did not load the length.");

	count_step_a: assert property (disable iff (!nrst_i) // R5
		pop && !start_wr && state_r == tone_pkg::ST_RUN && count_r > tone_pkg::LEN_W'(1)
		|=> count_r == $past(count_r) - 1'b1 && state_r == tone_pkg::ST_RUN)
		else $error("Length count did not step once per sample.");

	burst_end_a: assert property (disable iff (!nrst_i) // R24
		s_last_sample |=> state_r == tone_pkg::ST_IDLE && !tone_active_o)
		else $error("Burst did not end when the count expired.");

	boot_time_a: assert property (disable iff (!nrst_i) // R20
		s_boot_end |=> !coef_load_busy_o)
		else $error("Boot load did not end on time.");

	boot_hold_a: assert property (disable iff (!nrst_i) // R20
		$rose(nrst_i) |-> coef_load_busy_o && !tone_active_o)
		else $error("Boot load not busy after reset.");

	rotate_a: assert property (disable iff (!nrst_i) // R23
		pop && !start_wr && state_r == tone_pkg::ST_RUN |=> y_r == $past(y_nxt))
		else $error("Oscillator did not rotate.");

	play_mute_a: assert property (disable iff (!nrst_i) // R17
		tone_active_o && pop |=> dac_valid_o && $past(pb_l) == '0 && $past(pb_r) == '0)
		else $error("Playback not muted during tone.");

	mono_sel_a: assert property (disable iff (!nrst_i) // R22
		pop && mono_r[tone_pkg::MONO_MSB:tone_pkg::MONO_LSB] == tone_pkg::MONO_AVG
		|=> dac_data_o == $past(avg))
		else $error("Mono average not selected.");

	dac_hold_a: assert property (disable iff (!nrst_i) // R1
		dac_valid_o && !dac_ready_i |=> dac_valid_o && $stable(dac_data_o))
		else $error("DAC word dropped under back-pressure.");
endmodule
`default_nettype wire

// File: hdl/tone_pkg.sv
// Shared constants and types for the key-click tone generator.
`default_nettype none
package tone_pkg;
	// Clock rate and the coefficient boot-load time that follows any reset.
	localparam int unsigned CLK_MHZ       = 250;
	localparam int unsigned BOOT_LOAD_US  = 100;
	localparam int unsigned BOOT_LOAD_CYC = BOOT_LOAD_US * CLK_MHZ;
	localparam int unsigned BOOT_CNT_W    = 16;

	// Byte register offsets.
	localparam logic [7:0] ADDR_MONO_SEL  = 8'h3f;
	localparam logic [7:0] ADDR_LEFT_LVL  = 8'h47;
	localparam logic [7:0] ADDR_RIGHT_LVL = 8'h48;
	localparam logic [7:0] ADDR_LEN_HIGH  = 8'h49;
	localparam logic [7:0] ADDR_LEN_MID   = 8'h4a;
	localparam logic [7:0] ADDR_LEN_LOW   = 8'h4b;
	localparam logic [7:0] ADDR_SIN_HIGH  = 8'h4c;
	localparam logic [7:0] ADDR_SIN_LOW   = 8'h4d;
	localparam logic [7:0] ADDR_COS_HIGH  = 8'h4e;
	localparam logic [7:0] ADDR_COS_LOW   = 8'h4f;
	localparam logic [7:0] ADDR_CONTROL   = 8'h50;

	// Reset values.
	localparam logic [7:0] RST_MONO_SEL  = 8'h00;
	localparam logic [7:0] RST_LEFT_LVL  = 8'h00;
	localparam logic [7:0] RST_RIGHT_LVL = 8'h00;
	localparam logic [7:0] RST_LEN_HIGH  = 8'h00;
	localparam logic [7:0] RST_LEN_MID   = 8'h00;
	localparam logic [7:0] RST_LEN_LOW   = 8'hee;
	localparam logic [7:0] RST_SIN_HIGH  = 8'h10;
	localparam logic [7:0] RST_SIN_LOW   = 8'hd8;
	localparam logic [7:0] RST_COS_HIGH  = 8'h7e;
	localparam logic [7:0] RST_COS_LOW   = 8'he3;

	// Field positions.
	localparam int unsigned LEVEL_MSB  = 5;
	localparam int unsigned LEVEL_LSB  = 0;
	localparam int unsigned MASTER_MSB = 7;
	localparam int unsigned MASTER_LSB = 6;
	localparam int unsigned MONO_MSB   = 5;
	localparam int unsigned MONO_LSB   = 4;
	localparam int unsigned CTRL_START = 0;
	localparam int unsigned CTRL_MUTE  = 1;
	localparam int unsigned CTRL_BOOT  = 2;

	// Datapath widths and fixed-point scaling.
	localparam int unsigned SAMPLE_W = 16;
	localparam int unsigned LEN_W    = 24;
	localparam int unsigned COEF_FRAC = 15;
	localparam logic [6:0]  GAIN_FRAC = 7'h0e;
	localparam logic [6:0]  DB_PER_SHIFT   = 7'h06;
	localparam logic [6:0]  MASTER_STEP_DB = 7'h06;
	localparam logic signed [15:0] SAMPLE_MAX = 16'sh7fff;
	localparam logic signed [15:0] SAMPLE_MIN = -16'sh7fff - 16'sh0001;
	localparam logic signed [15:0] OSC_START  = 16'sh7fff;

	// Gains of +2, +1, 0, -1, -2 and -3 dB in Q14; whole 6 dB steps are shifts.
	localparam logic [15:0] GAIN_MANT [6] = '{16'h5092, 16'h47cf, 16'h4000,
		16'h390a, 16'h32d6, 16'h2d4f};

	// Playback FIFO shape: one word holds a left and a right sample.
	localparam int unsigned FIFO_W     = 32;
	localparam int unsigned FIFO_DEPTH = 8;

	// Mono DAC input selection.
	typedef enum logic [1:0] {
		MONO_LEFT  = 2'h0,
		MONO_RIGHT = 2'h1,
		MONO_AVG   = 2'h2,
		MONO_OFF   = 2'h3
	} mono_sel_t;

	// Generator states, one-hot.
	localparam int unsigned BOOT_IDX = 0;
	localparam int unsigned IDLE_IDX = 1;
	localparam int unsigned RUN_IDX  = 2;
	typedef enum logic [2:0] {
		ST_BOOT = 3'h1,
		ST_IDLE = 3'h2,
		ST_RUN  = 3'h4
	} tone_state_t;
endpackage
`default_nettype wire

// File: hdl/sample_stream_if.sv
// Valid/ready stream between the generator core and its playback FIFO.
`default_nettype none
interface sample_stream_if #(parameter int unsigned W = 32);
	logic         in_valid;
	logic         in_ready;
	logic [W-1:0] in_data;
	logic         out_valid;
	logic         out_ready;
	logic [W-1:0] out_data;
	modport fifo (input in_valid, in_data, out_ready, output in_ready, out_valid, out_data);
	modport user (output in_valid, in_data, out_ready, input in_ready, out_valid, out_data);
endinterface
`default_nettype wire

// File: hdl/tone_fifo.sv
// Synchronous FIFO with registered ready and valid flags.
`default_nettype none
module tone_fifo #(
	parameter int unsigned WIDTH = 32,
	parameter int unsigned DEPTH = 8
) (
	input  wire logic      clk_sys_i,
	input  wire logic      nrst_i,
	input  wire logic      ce_i,
	sample_stream_if.fifo  s
);
	// DEPTH must be a power of two so that the pointers wrap by themselves.
	localparam int unsigned AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem_r [DEPTH];
	logic [AW-1:0]    wr_ptr_r;
	logic [AW-1:0]    rd_ptr_r;
	logic [AW:0]      count_r;
	logic [AW:0]      count_nxt;
	logic             in_ready_r;
	logic             out_valid_r;
	logic             push;
	logic             pop;

	// Handshakes and next occupancy.
	assign push      = s.in_valid & in_ready_r;
	assign pop       = s.out_ready & out_valid_r;
	assign count_nxt = count_r + (AW+1)'(push) - (AW+1)'(pop);

	// Storage has no reset; only words marked valid are ever read.
	always_ff @(posedge clk_sys_i) begin
		if (ce_i && push) begin
			mem_r[wr_ptr_r] <= s.in_data;
		end
	end

	// Pointers, count and flags; flags come from the next count so they stay honest.
	always_ff @(posedge clk_sys_i) begin
		if (!nrst_i) begin
			wr_ptr_r    <= '0;
			rd_ptr_r    <= '0;
			count_r     <= '0;
			in_ready_r  <= 1'b1;
			out_valid_r <= 1'b0;
		end else if (ce_i) begin
			wr_ptr_r    <= wr_ptr_r + AW'(push);
			rd_ptr_r    <= rd_ptr_r + AW'(pop);
			count_r     <= count_nxt;
			in_ready_r  <= count_nxt != (AW+1)'(DEPTH);
			out_valid_r <= count_nxt != '0;
		end
	end

	assign s.in_ready  = in_ready_r;
	assign s.out_valid = out_valid_r;
	assign s.out_data  = mem_r[rd_ptr_r];
endmodule
`default_nettype wire

// File: tb/dac_sink.sv
// Behavioural mono DAC that takes finished samples from the block.
`default_nettype none
module dac_sink (
	input  wire logic        clk_sys_i,
	input  wire logic        stall_i,
	input  wire logic        dac_valid_i,
	input  wire logic [15:0] dac_data_i,
	output logic             dac_ready_o
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [15:0] got [$];

	// A stalling converter lets the playback FIFO fill up behind it.
	assign dac_ready_o = !stall_i;

	// Every sample accepted on an edge is queued for the bench to inspect.
	always @(posedge clk_sys_i) begin
		if (dac_valid_i && dac_ready_o) begin
			got.push_back(dac_data_i);
		end
	end
endmodule
`default_nettype wire

// File: tb/tb_top.sv
// Self-checking bench for the key-click tone generator.
`default_nettype none
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int unsigned BOOT = 20;
	logic        clk_sys_i, nrst_i, ce_i, reg_wr_i, reg_rd_i;
	logic [7:0]  reg_addr_i, reg_wdata_i, reg_rdata_o;
	logic        pb_valid_i, pb_ready_o, dac_valid_o, dac_ready_i;
	logic [15:0] pb_left_i, pb_right_i, dac_data_o, v;
	logic        tone_active_o, coef_load_busy_o, stall, r;
	int          n_errors, cmp_count, cyc, n;
	// Reset values, with an unmapped address at the end that must read zero.
	localparam logic [7:0] RA [11] = '{8'h47, 8'h48, 8'h49, 8'h4a, 8'h4b, 8'h4c, 8'h4d,
		8'h4e, 8'h4f, 8'h3f, 8'h51};
	localparam logic [7:0] RV [11] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'hee, 8'h10, 8'hd8,
		8'h7e, 8'he3, 8'h00, 8'h00};
	localparam logic [7:0] WV [9] = '{8'h2a, 8'hd5, 8'h01, 8'h77, 8'h00, 8'h12, 8'h34,
		8'h56, 8'h78};
	localparam logic [15:0] MONO [4] = '{16'h0100, 16'h0300, 16'h0200, 16'h0000};

	tone_generator #(.BOOT_LOAD_CYCLES(BOOT)) u_dut (
		.clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .ce_i(ce_i), .reg_wr_i(reg_wr_i),
		.reg_rd_i(reg_rd_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
		.reg_rdata_o(reg_rdata_o), .pb_valid_i(pb_valid_i), .pb_ready_o(pb_ready_o),
		.pb_left_i(pb_left_i), .pb_right_i(pb_right_i), .dac_valid_o(dac_valid_o),
		.dac_ready_i(dac_ready_i), .dac_data_o(dac_data_o), .tone_active_o(tone_active_o),
		.coef_load_busy_o(coef_load_busy_o));

	dac_sink u_sink (.clk_sys_i(clk_sys_i), .stall_i(stall), .dac_valid_i(dac_valid_o),
		.dac_data_i(dac_data_o), .dac_ready_o(dac_ready_i));

	initial begin
		clk_sys_i = 1'b0;
		forever #2 clk_sys_i = ~clk_sys_i;
	end

	task automatic test_done();
		if (n_errors == 0 && cmp_count > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	// The run should take well under a thousand cycles; a hang is cut off here.
	always @(posedge clk_sys_i) begin
		cyc++;
		if (cyc == 6000) begin
			n_errors++;
			test_done();
		end
	end

	task automatic chk(input logic [23:0] g, input logic [23:0] e);
		cmp_count++;
		if (g !== e) begin
			n_errors++;
			$display("wrong value at %0t: got %h expected %h", $time, g, e);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		reg_addr_i = a;
		reg_wdata_i = d;
		reg_wr_i = 1'b1;
		@(posedge clk_sys_i);
		#1 reg_wr_i = 1'b0;
		// An idle edge keeps the strobe from being lowered and raised in one step.
		@(posedge clk_sys_i);
		#1;
	endtask

	// Read data is registered on the read edge, so it is settled one step later.
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		reg_addr_i = a;
		reg_rd_i = 1'b1;
		@(posedge clk_sys_i);
		#1 reg_rd_i = 1'b0;
		chk(reg_rdata_o, e);
		@(posedge clk_sys_i);
		#1;
	endtask

	// Holds one playback word until the FIFO takes it.
	task automatic push(input logic [15:0] lf, input logic [15:0] rt);
		int k;
		pb_left_i = lf;
		pb_right_i = rt;
		pb_valid_i = 1'b1;
		for (k = 0; k < 50 && pb_ready_o !== 1'b1; k++) begin
			@(posedge clk_sys_i);
			#1;
		end
		@(posedge clk_sys_i);
		#1 pb_valid_i = 1'b0;
	endtask

	task automatic get(output logic [15:0] d);
		int k;
		for (k = 0; k < 50 && u_sink.got.size() == 0; k++) begin
			@(posedge clk_sys_i);
			#1;
		end
		d = (u_sink.got.size() > 0) ? u_sink.got.pop_front() : 16'hdead;
	endtask

	// Resets the block and measures how long the boot coefficient load lasts.
	task automatic do_reset();
		nrst_i = 1'b0;
		repeat (2) @(posedge clk_sys_i);
		#1 nrst_i = 1'b1;
		n = 0;
		while (coef_load_busy_o === 1'b1 && n < 100) begin
			@(posedge clk_sys_i);
			#1 n++;
		end
	endtask

	initial begin
		{nrst_i, reg_wr_i, reg_rd_i, pb_valid_i, stall} = '0;
		ce_i = 1'b1;
		{reg_addr_i, reg_wdata_i, pb_left_i, pb_right_i} = '0;
		nrst_i = 1'b0;
		repeat (2) @(posedge clk_sys_i);
		#1 nrst_i = 1'b1;
		chk(coef_load_busy_o, 1'b1);
		wr(8'h50, 8'h01);
		chk(tone_active_o, 1'b0);
		n = 1;
		// The host keeps clear of the coefficient memory until the boot load is over.
		while (coef_load_busy_o === 1'b1 && n < 100) begin
			@(posedge clk_sys_i);
			#1 n++;
		end
		chk(n >= BOOT - 1 && n <= BOOT + 1, 1'b1);
		for (int i = 0; i < 11; i++) rd(RA[i], RV[i]);
		for (int i = 0; i < 9; i++) wr(RA[i], WV[i]);
		for (int i = 0; i < 9; i++) rd(RA[i], WV[i]);
		do_reset();
		chk(24'(n), 24'(BOOT));
		// Writes while the clock enable is low must leave the registers alone.
		ce_i = 1'b0;
		wr(8'h4b, 8'h55);
		ce_i = 1'b1;
		rd(8'h4b, 8'hee);
		// Idle tone is silent, so the selector alone decides the mono sample.
		for (int s = 0; s < 4; s++) begin
			wr(8'h3f, 8'(s << 4));
			push(16'h0100, 16'h0300);
			get(v);
			chk(v, MONO[s]);
		end
		wr(8'h3f, 8'h00);
		// A stalled converter must see the FIFO refuse, then every word in order.
		stall = 1'b1;
		n = 0;
		pb_valid_i = 1'b1;
		repeat (16) begin
			pb_left_i = 16'(n);
			r = pb_ready_o;
			@(posedge clk_sys_i);
			#1;
			if (r === 1'b1) n++;
		end
		pb_valid_i = 1'b0;
		chk(pb_ready_o, 1'b0);
		chk(n >= 8 && n <= 10, 1'b1);
		stall = 1'b0;
		for (int i = 0; i < n; i++) begin
			get(v);
			chk(v, 16'(i));
		end
		// A two-sample burst mutes playback and begins at the sine zero crossing.
		wr(8'h4b, 8'h02);
		wr(8'h50, 8'h01);
		chk(tone_active_o, 1'b1);
		rd(8'h50, 8'h01);
		push(16'h1000, 16'h1000);
		get(v);
		chk(v, 16'h0000);
		push(16'h1000, 16'h1000);
		get(v);
		// Second sample is one rotation of the default coefficients at the loudest level.
		chk(v, 16'h1533);
		chk(tone_active_o, 1'b0);
		push(16'h1000, 16'h1000);
		get(v);
		chk(v, 16'h1000);
		// One master step takes 6 dB off the same burst on both channels.
		wr(8'h48, 8'h40);
		wr(8'h50, 8'h01);
		push(16'h1000, 16'h1000);
		get(v);
		chk(v, 16'h0000);
		push(16'h1000, 16'h1000);
		get(v);
		chk(v, 16'h0a99);
		// The host mute bit silences playback without any burst running.
		wr(8'h50, 8'h02);
		push(16'h1000, 16'h1000);
		get(v);
		chk(v, 16'h0000);
		rd(8'h50, 8'h02);
		wr(8'h50, 8'h00);
		wr(8'h4b, 8'h00);
		wr(8'h50, 8'h01);
		chk(tone_active_o, 1'b0);
		test_done();
	end
endmodule
`default_nettype wire
